// File: hw/autoneg_ability_regs.sv
// Advertisement and partner ability registers with their management port
`timescale 1ns/1ps

module autoneg_ability_regs (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Pins
  input wire logic duplex_strap_pin,
  input wire logic mdc,
  input wire logic mdio_i,
  output an_regs_pkg::mdio_drive_t mdio_drive,
  // Port address on the management bus
  input wire logic [4:0] phy_addr,
  // Negotiation logic events
  input an_regs_pkg::an_event_t an_event,
  input wire logic page_flag_clear,
  // Views for the negotiation logic
  output logic [15:0] local_advertise,
  output logic [15:0] partner_base_page,
  output logic page_received,
  output logic [3:0] status_duplex_ability
);
  import an_regs_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    mdio_state_t fsm;
    logic mdc_s1;
    logic mdc_s2;
    logic mdc_prev;
    logic dio_s1;
    logic dio_s2;
    logic strap_s1;
    logic strap_s2;
    logic [1:0] strap_cnt;
    logic strap_done;
    logic [4:0] cnt;
    logic [11:0] hdr;
    logic [15:0] shreg;
    mdio_drive_t drv;
    logic [15:0] adv;
    logic ack;
    logic [15:0] partner;
    logic page_flag;
  } regs_state_t;

  localparam regs_state_t STATE_RESET = '{
    fsm: ST_HUNT,
    mdc_s1: 1'b0,
    mdc_s2: 1'b0,
    mdc_prev: 1'b0,
    dio_s1: 1'b1,
    dio_s2: 1'b1,
    strap_s1: 1'b0,
    strap_s2: 1'b0,
    strap_cnt: 2'h0,
    strap_done: 1'b0,
    cnt: 5'h00,
    hdr: 12'h000,
    shreg: 16'h0000,
    drv: '{mdio_o: 1'b1, mdio_oe_n: 1'b1},
    adv: ADV_RESET,
    ack: 1'b0,
    partner: 16'h0000,
    page_flag: 1'b0
  };

  regs_state_t st;
  regs_state_t next_st;

  logic mdc_rise;
  logic mdc_fall;
  logic bit_in;
  logic [11:0] hdr_full;
  logic [15:0] wr_word;
  logic [15:0] adv_view;
  logic adv_commit;

  // ----------------------------------------------------------------
  // Register views
  // ----------------------------------------------------------------
  always_comb begin
    adv_view = st.adv & ADV_WRITE_MASK;
    adv_view[ADV_ACK] = st.ack;
    adv_view[ADV_T4] = 1'b0;
    adv_view[4:0] = SELECTOR_8023;
  end

  function automatic logic [15:0] read_word(input logic [4:0] regad,
                                             input logic [15:0] adv_w,
                                             input logic [15:0] partner_w);
    logic [15:0] w;
    w = 16'h0000;
    if (regad == REG_LOCAL_ADVERTISE) begin
      w = adv_w;
    end else if (regad == REG_PARTNER_BASE) begin
      w = partner_w;
    end
    return w;
  endfunction : read_word

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    adv_commit = 1'b0;
    // Two flops on every pin before use
    next_st.mdc_s1 = mdc;
    next_st.mdc_s2 = st.mdc_s1;
    next_st.mdc_prev = st.mdc_s2;
    next_st.dio_s1 = mdio_i;
    next_st.dio_s2 = st.dio_s1;
    next_st.strap_s1 = duplex_strap_pin;
    next_st.strap_s2 = st.strap_s1;

    mdc_rise = st.mdc_s2 & ~st.mdc_prev;
    mdc_fall = ~st.mdc_s2 & st.mdc_prev;
    bit_in = st.dio_s2;
    hdr_full = {st.hdr[10:0], bit_in};
    wr_word = {st.shreg[14:0], bit_in};

    // Strap caught once the synchroniser has settled after release
    if (!st.strap_done) begin
      if (st.strap_cnt == STRAP_WAIT) begin
        next_st.strap_done = 1'b1;
        next_st.adv[ADV_TX_FD] = st.strap_s2;
        next_st.adv[ADV_10_FD] = st.strap_s2;
      end else begin
        next_st.strap_cnt = st.strap_cnt + 2'h1;
      end
    end

    // Management frame engine
    unique case (st.fsm)
      ST_HUNT: begin
        // Preamble is optional; an idle line sits high
        if (mdc_rise && !bit_in) begin
          next_st.fsm = ST_START;
        end
      end
      ST_START: begin
        if (mdc_rise) begin
          next_st.cnt = 5'h00;
          next_st.fsm = bit_in ? ST_HEADER : ST_START;
        end
      end
      ST_HEADER: begin
        if (mdc_rise) begin
          next_st.hdr = hdr_full;
          next_st.cnt = st.cnt + 5'h01;
          if (st.cnt == HDR_LAST) begin
            next_st.cnt = 5'h00;
            next_st.fsm = ST_SKIP;
            if (hdr_full[9:5] == phy_addr && hdr_full[11:10] == OP_READ) begin
              next_st.fsm = ST_READ;
              next_st.shreg = read_word(hdr_full[4:0], adv_view, st.partner);
            end else if (hdr_full[9:5] == phy_addr && hdr_full[11:10] == OP_WRITE) begin
              next_st.fsm = ST_WRITE;
            end
          end
        end
      end
      ST_READ: begin
        if (mdc_rise) begin
          next_st.cnt = st.cnt + 5'h01;
        end
        // Data changes on the falling edge so it is stable at the rise
        if (mdc_fall) begin
          if (st.cnt == TA_DRIVE) begin
            next_st.drv.mdio_oe_n = 1'b0;
            next_st.drv.mdio_o = 1'b0;
          end else if (st.cnt >= DATA_FIRST && st.cnt <= DATA_LAST) begin
            next_st.drv.mdio_o = st.shreg[15];
            next_st.shreg = {st.shreg[14:0], 1'b0};
          end else if (st.cnt == FRAME_END) begin
            next_st.drv.mdio_oe_n = 1'b1;
            next_st.drv.mdio_o = 1'b1;
            next_st.fsm = ST_HUNT;
          end
        end
      end
      ST_WRITE: begin
        if (mdc_rise) begin
          next_st.cnt = st.cnt + 5'h01;
          if (st.cnt >= DATA_FIRST) begin
            next_st.shreg = wr_word;
          end
          if (st.cnt == DATA_LAST) begin
            next_st.fsm = ST_HUNT;
            if (st.hdr[4:0] == REG_LOCAL_ADVERTISE) begin
              // Read-only bits are masked off; reserved bits keep what was written
              adv_commit = 1'b1;
              next_st.adv = wr_word & ADV_WRITE_MASK;
            end
          end
        end
      end
      ST_SKIP: begin
        // Frames for other ports pass without a response
        if (mdc_rise) begin
          next_st.cnt = st.cnt + 5'h01;
          if (st.cnt == DATA_LAST) begin
            next_st.fsm = ST_HUNT;
          end
        end
      end
      default: begin
        next_st.fsm = ST_HUNT;
      end
    endcase

    // Acknowledge: set wins over a restart
    if (an_event.ack_clear) begin
      next_st.ack = 1'b0;
    end
    if (an_event.ack_set) begin
      next_st.ack = 1'b1;
    end

    // Partner word and its flag; a load wins over a clear
    if (page_flag_clear) begin
      next_st.page_flag = 1'b0;
    end
    if (an_event.partner_load) begin
      next_st.partner = an_event.partner_word;
      next_st.page_flag = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st <= STATE_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign mdio_drive = st.drv;
  assign local_advertise = adv_view;
  assign partner_base_page = st.partner;
  assign page_received = st.page_flag;
  // Bits 14..11 of the status register
  assign status_duplex_ability = {st.strap_s2, 1'b1, st.strap_s2, 1'b1};

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  a_fixed_bits: assert property (
    local_advertise[4:0] == SELECTOR_8023 && !local_advertise[ADV_T4])
    else $error("fixed advertisement bits wrong");

  a_ack_set: assert property (
    an_event.ack_set |=> local_advertise[ADV_ACK] ##1
      (local_advertise[ADV_ACK] || $past(an_event.ack_clear)))
    else $error("acknowledge not set");

  a_partner_load: assert property (
    an_event.partner_load |=> partner_base_page == $past(an_event.partner_word))
    else $error("partner word not loaded");

  a_partner_hold: assert property (
    !an_event.partner_load |=> $stable(partner_base_page))
    else $error("partner word changed without load");

  a_page_flag: assert property (
    an_event.partner_load |=> page_received ##1 (page_received || $past(page_flag_clear)))
    else $error("page flag not set");

  a_strap_load: assert property (
    $rose(st.strap_done) |->
      st.adv[ADV_TX_FD] == $past(st.strap_s2) && st.adv[ADV_10_FD] == $past(st.strap_s2))
    else $error("strap not loaded");

  a_adv_write: assert property (
    adv_commit |=> local_advertise[15] == $past(wr_word[15]) &&
      local_advertise[13] == $past(wr_word[13]) && local_advertise[10] == $past(wr_word[10]))
    else $error("advertisement write lost");

  a_status_dup: assert property (
    status_duplex_ability[3] == status_duplex_ability[1] &&
      status_duplex_ability[2] && status_duplex_ability[0])
    else $error("status duplex bits wrong");

  a_drive_read: assert property (
    !mdio_drive.mdio_oe_n |-> st.fsm == ST_READ)
    else $error("pin driven outside a read");

  a_ack_clear: assert property (
    an_event.ack_clear && !an_event.ack_set |=> !local_advertise[ADV_ACK])
    else $error("acknowledge not cleared");

  a_flag_clear: assert property (
    page_flag_clear && !an_event.partner_load |=> !page_received)
    else $error("page flag not cleared");

  a_adv_hold: assert property (
    st.strap_done && !adv_commit |=> $stable(st.adv))
    else $error("advertisement changed without a write");

  a_ta_low: assert property (
    $fell(mdio_drive.mdio_oe_n) |-> !mdio_drive.mdio_o)
    else $error("turnaround not driven low");

  a_read_release: assert property (
    st.fsm == ST_READ && mdc_fall && st.cnt == FRAME_END |=> mdio_drive.mdio_oe_n)
    else $error("pin not released after a read");

endmodule : autoneg_ability_regs

// File: inc/an_regs_pkg.sv
// Constants and carrier types for the auto-negotiation ability registers
package an_regs_pkg;

  // ----------------------------------------------------------------
  // Register indices on the management interface
  // ----------------------------------------------------------------
  localparam logic [4:0] REG_LOCAL_ADVERTISE = 5'h04;
  localparam logic [4:0] REG_PARTNER_BASE = 5'h05;

  // ----------------------------------------------------------------
  // Advertisement register layout
  // ----------------------------------------------------------------
  localparam int ADV_NEXT_PAGE = 15;
  localparam int ADV_ACK = 14;
  localparam int ADV_REMOTE_FAULT = 13;
  localparam int ADV_PAUSE = 10;
  localparam int ADV_T4 = 9;
  localparam int ADV_TX_FD = 8;
  localparam int ADV_TX_HD = 7;
  localparam int ADV_10_FD = 6;
  localparam int ADV_10_HD = 5;
  localparam logic [15:0] ADV_WRITE_MASK = 16'hbde0;
  localparam logic [15:0] ADV_RESET = 16'h00a0;
  localparam logic [4:0] SELECTOR_8023 = 5'h01;

  // ----------------------------------------------------------------
  // Management frame framing
  // ----------------------------------------------------------------
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [4:0] HDR_LAST = 5'h0b;
  localparam logic [4:0] TA_DRIVE = 5'h01;
  localparam logic [4:0] DATA_FIRST = 5'h02;
  localparam logic [4:0] DATA_LAST = 5'h11;
  localparam logic [4:0] FRAME_END = 5'h12;

  // ----------------------------------------------------------------
  // Strap capture delay after reset release, in clk_sys cycles
  // ----------------------------------------------------------------
  localparam logic [1:0] STRAP_WAIT = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    ST_HUNT = 6'b000001,
    ST_START = 6'b000010,
    ST_HEADER = 6'b000100,
    ST_READ = 6'b001000,
    ST_WRITE = 6'b010000,
    ST_SKIP = 6'b100000
  } mdio_state_t;

  typedef struct packed {
    logic partner_load;
    logic [15:0] partner_word;
    logic ack_set;
    logic ack_clear;
  } an_event_t;

  typedef struct packed {
    logic mdio_o;
    logic mdio_oe_n;
  } mdio_drive_t;

endpackage : an_regs_pkg

// File: tb/mdio_master.sv
// Station management controller model driving the management pins
`timescale 1ns/1ps

module mdio_master (
  // Clock
  input wire logic clk_sys,
  // Management pins
  output logic mdc,
  output logic mdio_m,
  output logic mdio_m_en,
  input wire logic mdio_line
);
  import an_regs_pkg::*;

  initial begin
    mdc = 1'b0;
    mdio_m = 1'b1;
    mdio_m_en = 1'b0;
  end

  // ----------------------------------------------------------------
  // One bit, 8 cycles a phase; line sampled at the rise
  // ----------------------------------------------------------------
  task automatic bit_cycle(input logic b, input logic en, output logic s);
    @(posedge clk_sys);
    mdc <= 1'b0;
    mdio_m <= b;
    mdio_m_en <= en;
    repeat (8) @(posedge clk_sys);
    mdc <= 1'b1;
    s = mdio_line;
    repeat (7) @(posedge clk_sys);
  endtask : bit_cycle

  // ----------------------------------------------------------------
  // Whole frame, no preamble; clock parks low afterwards
  // ----------------------------------------------------------------
  task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] rd, output logic ta);
    logic [13:0] hdr;
    logic [15:0] wm;
    logic s;
    logic wr;
    hdr = {2'b01, op, pa, ra};
    wm = wd & 16'he7ff;
    wr = (op == OP_WRITE);
    for (int i = 13; i >= 0; i--) begin
      bit_cycle(hdr[i], 1'b1, s);
    end
    bit_cycle(1'b1, wr, s);
    bit_cycle(1'b0, wr, ta);
    for (int i = 15; i >= 0; i--) begin
      bit_cycle(wm[i], wr, s);
      rd[i] = s;
    end
    @(posedge clk_sys);
    mdc <= 1'b0;
    mdio_m_en <= 1'b0;
    repeat (12) @(posedge clk_sys);
  endtask : frame

endmodule : mdio_master

// File: tb/testbench.sv
// Self-checking testbench for the auto-negotiation ability registers
`timescale 1ns/1ps

module testbench;
  import an_regs_pkg::*;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clk_sys;
  logic rstn;
  logic duplex_strap_pin;
  logic page_flag_clear;
  logic page_received;
  logic mdc;
  logic mdio_m;
  logic mdio_m_en;
  logic mdio_line;
  logic ta;
  logic [4:0] phy_addr;
  logic [15:0] local_advertise;
  logic [15:0] partner_base_page;
  logic [15:0] rd;
  logic [3:0] status_duplex_ability;
  an_event_t an_event;
  mdio_drive_t mdio_drive;
  int err_count;
  int n_compared;

  // Pull-up wins when neither side drives
  assign mdio_line = !mdio_drive.mdio_oe_n ? mdio_drive.mdio_o : (mdio_m_en ? mdio_m : 1'b1);

  autoneg_ability_regs u_autoneg_ability_regs (
    .clk_sys(clk_sys), .rstn(rstn), .duplex_strap_pin(duplex_strap_pin), .mdc(mdc),
    .mdio_i(mdio_line), .mdio_drive(mdio_drive), .phy_addr(phy_addr), .an_event(an_event),
    .page_flag_clear(page_flag_clear), .local_advertise(local_advertise),
    .partner_base_page(partner_base_page), .page_received(page_received),
    .status_duplex_ability(status_duplex_ability));

  mdio_master u_mdio_master (
    .clk_sys(clk_sys), .mdc(mdc), .mdio_m(mdio_m), .mdio_m_en(mdio_m_en),
    .mdio_line(mdio_line));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic rd_reg(input logic [4:0] ra, input logic [15:0] exp);
    u_mdio_master.frame(OP_READ, phy_addr, ra, 16'h0000, rd, ta);
    check("turnaround", 16'h0000, {15'h0, ta});
    check("read data", exp, rd);
  endtask : rd_reg

  task automatic wr_reg(input logic [4:0] ra, input logic [15:0] wd);
    u_mdio_master.frame(OP_WRITE, phy_addr, ra, wd, rd, ta);
  endtask : wr_reg

  task automatic pulse(input an_event_t ev, input logic clr);
    @(posedge clk_sys);
    an_event <= ev;
    page_flag_clear <= clr;
    @(posedge clk_sys);
    an_event <= '0;
    page_flag_clear <= 1'b0;
    #1;
  endtask : pulse

  task automatic do_reset(input logic strap);
    @(posedge clk_sys);
    rstn <= 1'b0;
    duplex_strap_pin <= strap;
    @(posedge clk_sys);
    #1 check("advertise in reset", 16'h00a1, local_advertise);
    @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (6) @(posedge clk_sys);
    #1;
  endtask : do_reset

  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : give_verdict

  // ----------------------------------------------------------------
  // Watchdog, several times the expected run
  // ----------------------------------------------------------------
  initial begin
    repeat (60000) @(posedge clk_sys);
    err_count++;
    give_verdict();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    rstn = 1'b0;
    duplex_strap_pin = 1'b1;
    phy_addr = 5'h03;
    an_event = '0;
    page_flag_clear = 1'b0;
    err_count = 0;
    n_compared = 0;
    for (int s = 1; s >= 0; s--) begin
      do_reset(s[0]);
      check("duplex status", {12'h0, s[0], 1'b1, s[0], 1'b1}, {12'h0, status_duplex_ability});
      rd_reg(REG_LOCAL_ADVERTISE, {7'h0, s[0], 1'b1, s[0], 1'b1, 5'h01});
      rd_reg(REG_PARTNER_BASE, 16'h0000);
      $display("test reset with strap %0d done", s);
    end
    // Reserved bits go out as zero, so the readback is fully known
    wr_reg(REG_LOCAL_ADVERTISE, 16'hffff);
    rd_reg(REG_LOCAL_ADVERTISE, 16'ha5e1);
    check("advertise view", 16'ha5e1, local_advertise);
    wr_reg(REG_LOCAL_ADVERTISE, 16'h0000);
    rd_reg(REG_LOCAL_ADVERTISE, 16'h0001);
    $display("test advertisement write done");
    pulse(19'h00002, 1'b0);
    rd_reg(REG_LOCAL_ADVERTISE, 16'h4001);
    pulse(19'h00003, 1'b0);
    check("ack set wins", 16'h4001, local_advertise);
    pulse(19'h00001, 1'b0);
    check("ack cleared", 16'h0001, local_advertise);
    $display("test acknowledge done");
    pulse({1'b1, 16'ha5a5, 2'b00}, 1'b0);
    check("partner word", 16'ha5a5, partner_base_page);
    check("page flag set", 16'h0001, {15'h0, page_received});
    wr_reg(REG_PARTNER_BASE, 16'h1234);
    rd_reg(REG_PARTNER_BASE, 16'ha5a5);
    pulse('0, 1'b1);
    check("page flag cleared", 16'h0000, {15'h0, page_received});
    pulse({1'b1, 16'h5a5a, 2'b00}, 1'b1);
    check("load beats clear", 16'h0001, {15'h0, page_received});
    rd_reg(REG_PARTNER_BASE, 16'h5a5a);
    $display("test partner page done");
    rd_reg(5'h06, 16'h0000);
    u_mdio_master.frame(OP_READ, 5'h07, REG_LOCAL_ADVERTISE, 16'h0000, rd, ta);
    check("foreign address idle", 16'hffff, rd);
    // Writes that must not land: unmapped register, other port, reserved opcode
    wr_reg(5'h06, 16'hffff);
    u_mdio_master.frame(OP_WRITE, 5'h07, REG_LOCAL_ADVERTISE, 16'hffff, rd, ta);
    u_mdio_master.frame(2'h0, phy_addr, REG_LOCAL_ADVERTISE, 16'hffff, rd, ta);
    check("reserved opcode idle", 16'hffff, rd);
    rd_reg(REG_LOCAL_ADVERTISE, 16'h0001);
    $display("test refusals done");
    give_verdict();
  end

endmodule : testbench
